/* buck_phase_voltage_regs.v */
`timescale 1ns/1ps
`default_nettype none

`include "buck_regs_map.vh"

// Behaviour
// [RQ1] shed enables bit4 second, bit3 first, reset 1
// [RQ2] bit2 selects second converter one/two phases
// [RQ3] bits1:0 decode first converter phases one-four
// [RQ4] three phases use 0/90/180 degree shift
// [RQ5] above two phases only on four-phase variant
// [RQ6] fuse ceilings read-only, writable in test mode
// [RQ7] codes map linearly 0.30 V plus 10 mV
// [RQ8] four writable setpoints, reset 0x46 (1.0 V)
// [RQ9] reserved bits read zero, writes ignored
module buck_phase_voltage_regs (
    // clock and reset
    input  wire        i_core_clk,
    input  wire        i_nrst,
    // register access from the host interface decoder
    input  wire [7:0]  i_addr,
    input  wire        i_page_hit,
    input  wire        i_wr_en,
    input  wire [7:0]  i_wr_data,
    input  wire        i_rd_en,
    output reg  [7:0]  o_rd_data,
    // device straps and test access
    input  wire        i_quad_variant,
    input  wire        i_test_mode,
    input  wire        i_fuse_load,
    input  wire [6:0]  i_fuse_ceiling_first,
    input  wire [6:0]  i_fuse_ceiling_second,
    // phase control towards the first converter
    output reg  [2:0]  o_phases_first,
    output reg  [3:0]  o_phase_active_first,
    output reg  [7:0]  o_phase_shift_deg_1,
    output reg  [7:0]  o_phase_shift_deg_2,
    output reg  [7:0]  o_phase_shift_deg_3,
    output reg         o_shed_enable_first,
    // phase control towards the second converter
    output reg  [1:0]  o_phases_second,
    output reg         o_shed_enable_second,
    // voltage codes and levels
    output wire [6:0]  o_setpoint_first_a,
    output wire [6:0]  o_setpoint_first_b,
    output wire [6:0]  o_setpoint_second_a,
    output wire [6:0]  o_setpoint_second_b,
    output reg  [6:0]  o_ceiling_code_first,
    output reg  [6:0]  o_ceiling_code_second,
    output wire [10:0] o_setpoint_first_a_mv,
    output wire [10:0] o_ceiling_first_mv
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg [1:0] quad_sync;     // variant strap, two stages
    reg [1:0] test_sync;     // test mode pin, two stages
    reg [1:0] fuse_sync;     // fuse load request, two stages
    reg       fuse_seen;     // previous synced fuse level
    wire      quad_variant;  // synced strap
    wire      test_mode;     // synced test mode
    wire      fuse_pulse;    // rising edge of fuse load

    // straps and test pins come from outside the clock domain
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            quad_sync <= 2'h0;
            test_sync <= 2'h0;
            fuse_sync <= 2'h0;
            fuse_seen <= 1'b0;
        end else begin
            quad_sync <= {quad_sync[0], i_quad_variant};
            test_sync <= {test_sync[0], i_test_mode};
            fuse_sync <= {fuse_sync[0], i_fuse_load};
            fuse_seen <= fuse_sync[1];
        end
    end

    assign quad_variant = quad_sync[1];
    assign test_mode    = test_sync[1];
    assign fuse_pulse   = fuse_sync[1] & ~fuse_seen;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire wr_hit;        // write strobe inside our page
    wire sel_conf;      // phase config selected
    wire sel_ceil_1;    // first ceiling selected
    wire sel_ceil_2;    // second ceiling selected
    wire sel_sp_1a;     // first converter setpoint a
    wire sel_sp_1b;     // first converter setpoint b
    wire sel_sp_2a;     // second converter setpoint a
    wire sel_sp_2b;     // second converter setpoint b

    assign wr_hit     = i_wr_en & i_page_hit;
    assign sel_conf   = (i_addr == `OFS_PHASE_CONFIG);
    assign sel_ceil_1 = (i_addr == `OFS_CEILING_FIRST);
    assign sel_ceil_2 = (i_addr == `OFS_CEILING_SECOND);
    assign sel_sp_1a  = (i_addr == `OFS_SETPOINT_FIRST_A);
    assign sel_sp_1b  = (i_addr == `OFS_SETPOINT_FIRST_B);
    assign sel_sp_2a  = (i_addr == `OFS_SETPOINT_SECOND_A);
    assign sel_sp_2b  = (i_addr == `OFS_SETPOINT_SECOND_B);

    // ----------------------------------------
    // phase configuration register
    // ----------------------------------------
    reg [4:0] phase_conf;   // only bits 4:0 are stored

    // bits 7:5 have no storage, so writes there are lost
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_conf <= `RST_PHASE_STORED;                  // [RQ1]
        end else if (wr_hit && sel_conf) begin
            phase_conf <= i_wr_data[4:0];                     // [RQ9]
        end
    end

    // ----------------------------------------
    // fuse-loaded ceilings
    // ----------------------------------------
    // fuse load wins over a test-mode write in the same cycle,
    // since the fuse value is the trusted one
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ceiling_code_first  <= `RST_CEILING;            // [RQ6]
            o_ceiling_code_second <= `RST_CEILING;
        end else if (fuse_pulse) begin
            o_ceiling_code_first  <= i_fuse_ceiling_first;    // [RQ6]
            o_ceiling_code_second <= i_fuse_ceiling_second;
        end else if (wr_hit && test_mode) begin
            // normal mode writes are ignored: read-only field
            if (sel_ceil_1) begin
                o_ceiling_code_first <= i_wr_data[6:0];       // [RQ6]
            end
            if (sel_ceil_2) begin
                o_ceiling_code_second <= i_wr_data[6:0];
            end
        end
    end

    // ----------------------------------------
    // setpoint registers
    // ----------------------------------------
    vcode_reg #(.RESET_CODE(`RST_SETPOINT)) u_sp_1a (         // [RQ8]
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_load     (wr_hit & sel_sp_1a),
        .i_code     (i_wr_data[6:0]),
        .o_code     (o_setpoint_first_a)
    );

    vcode_reg #(.RESET_CODE(`RST_SETPOINT)) u_sp_1b (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_load     (wr_hit & sel_sp_1b),
        .i_code     (i_wr_data[6:0]),
        .o_code     (o_setpoint_first_b)
    );

    vcode_reg #(.RESET_CODE(`RST_SETPOINT)) u_sp_2a (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_load     (wr_hit & sel_sp_2a),
        .i_code     (i_wr_data[6:0]),
        .o_code     (o_setpoint_second_a)
    );

    vcode_reg #(.RESET_CODE(`RST_SETPOINT)) u_sp_2b (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_load     (wr_hit & sel_sp_2b),
        .i_code     (i_wr_data[6:0]),
        .o_code     (o_setpoint_second_b)
    );

    // ----------------------------------------
    // millivolt views for monitoring
    // ----------------------------------------
    vcode_to_mv u_mv_sp (                                     // [RQ7]
        .i_code (o_setpoint_first_a),
        .o_mv   (o_setpoint_first_a_mv)
    );

    vcode_to_mv u_mv_ceil (
        .i_code (o_ceiling_code_first),
        .o_mv   (o_ceiling_first_mv)
    );

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    reg [7:0] next_rd_data;   // combinational read value

    // unmapped offsets and reserved bits read as zero
    always @* begin
        next_rd_data = 8'h00;
        if (sel_conf) begin
            next_rd_data = {3'h0, phase_conf};                // [RQ9]
        end else if (sel_ceil_1) begin
            next_rd_data = {1'b0, o_ceiling_code_first};
        end else if (sel_ceil_2) begin
            next_rd_data = {1'b0, o_ceiling_code_second};
        end else if (sel_sp_1a) begin
            next_rd_data = {1'b0, o_setpoint_first_a};
        end else if (sel_sp_1b) begin
            next_rd_data = {1'b0, o_setpoint_first_b};
        end else if (sel_sp_2a) begin
            next_rd_data = {1'b0, o_setpoint_second_a};
        end else if (sel_sp_2b) begin
            next_rd_data = {1'b0, o_setpoint_second_b};
        end
    end

    // read data registered, one cycle after the read strobe
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_data <= 8'h00;
        end else if (i_rd_en && i_page_hit) begin
            o_rd_data <= next_rd_data;
        end
    end

    // ----------------------------------------
    // phase decode
    // ----------------------------------------
    reg [1:0] eff_sel_first;  // selector after variant cap
    reg [2:0] next_phases_first;
    reg [3:0] next_active_first;
    reg [7:0] next_shift_1;
    reg [7:0] next_shift_2;
    reg [7:0] next_shift_3;

    // shift figures in degrees relative to phase 0
    always @* begin
        eff_sel_first = phase_conf[`PHASE_FIRST_HI:`PHASE_FIRST_LO];
        // dual variant can run at most two phases; register keeps
        // the written value so a readback shows what software wrote
        if (!quad_variant && eff_sel_first[1]) begin
            eff_sel_first = 2'h1;                             // [RQ5]
        end
        next_shift_1 = 8'h00;
        next_shift_2 = 8'h00;
        next_shift_3 = 8'h00;
        case (eff_sel_first)                                  // [RQ3]
            2'h0: begin
                next_phases_first = 3'h1;
                next_active_first = 4'h1;
            end
            2'h1: begin
                next_phases_first = 3'h2;
                next_active_first = 4'h3;
                next_shift_1      = 8'hb4;
            end
            2'h2: begin
                next_phases_first = 3'h3;
                next_active_first = 4'h7;
                next_shift_1      = 8'h5a;                    // [RQ4]
                next_shift_2      = 8'hb4;                    // [RQ4]
            end
            2'h3: begin
                next_phases_first = 3'h4;
                next_active_first = 4'hf;
                next_shift_1      = 8'h5a;
                next_shift_2      = 8'hb4;
                next_shift_3      = 8'h0e;  // 270 mod 256, low byte only
            end
            default: begin
                next_phases_first = 3'h1;
                next_active_first = 4'h1;
            end
        endcase
    end

    // controls registered so the converter never sees a glitch
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_phases_first       <= 3'h2;
            o_phase_active_first <= 4'h3;
            o_phase_shift_deg_1  <= 8'hb4;
            o_phase_shift_deg_2  <= 8'h00;
            o_phase_shift_deg_3  <= 8'h00;
            o_shed_enable_first  <= 1'b1;
            o_phases_second      <= 2'h2;
            o_shed_enable_second <= 1'b1;
        end else begin
            o_phases_first       <= next_phases_first;
            o_phase_active_first <= next_active_first;
            o_phase_shift_deg_1  <= next_shift_1;
            o_phase_shift_deg_2  <= next_shift_2;
            o_phase_shift_deg_3  <= next_shift_3;
            o_shed_enable_first  <= phase_conf[`BIT_SHED_FIRST];   // [RQ1]
            o_shed_enable_second <= phase_conf[`BIT_SHED_SECOND];  // [RQ1]
            o_phases_second      <= phase_conf[`BIT_PHASE_SECOND] ? 2'h2 : 2'h1; // [RQ2]
        end
    end

endmodule

`default_nettype wire

/* buck_phase_voltage_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the regulator register bank
// ----------------------------------------
module buck_phase_voltage_regs_chk (
    // clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    // host access
    input wire logic [7:0]  i_addr,
    input wire logic        i_page_hit,
    input wire logic        i_wr_en,
    input wire logic [7:0]  i_wr_data,
    input wire logic        i_rd_en,
    input wire logic [7:0]  o_rd_data,
    // straps and test access
    input wire logic        i_quad_variant,
    input wire logic        i_test_mode,
    input wire logic        i_fuse_load,
    // converter controls
    input wire logic [2:0]  o_phases_first,
    input wire logic [3:0]  o_phase_active_first,
    input wire logic [7:0]  o_phase_shift_deg_1,
    input wire logic [7:0]  o_phase_shift_deg_2,
    input wire logic        o_shed_enable_first,
    input wire logic [1:0]  o_phases_second,
    input wire logic        o_shed_enable_second,
    input wire logic [6:0]  o_setpoint_first_a,
    input wire logic [6:0]  o_ceiling_code_first,
    input wire logic [10:0] o_setpoint_first_a_mv,
    input wire logic [10:0] o_ceiling_first_mv
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // write strobe aimed at this page
    logic wr_hit;
    assign wr_hit = i_wr_en && i_page_hit;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_SETPOINT_LOAD: assert property (wr_hit && i_addr == 8'hd7 |=>
        o_setpoint_first_a == $past(i_wr_data[6:0])) else $error("setpoint not loaded");
    AST_READ_BACK: assert property (i_rd_en && i_page_hit && i_addr == 8'hd7 |=>
        o_rd_data == {1'h0, $past(o_setpoint_first_a)}) else $error("setpoint read wrong");
    AST_SETPOINT_MV: assert property (o_setpoint_first_a_mv ==
        11'h12c + 11'h00a * {4'h0, o_setpoint_first_a}) else $error("setpoint mv wrong");
    AST_CEILING_MV: assert property (o_ceiling_first_mv ==
        11'h12c + 11'h00a * {4'h0, o_ceiling_code_first}) else $error("ceiling mv wrong");
    // no test mode and no fuse edge: the ceiling is frozen
    AST_CEILING_LOCK: assert property ((!i_test_mode && !i_fuse_load) [*5] |=>
        $stable(o_ceiling_code_first)) else $error("ceiling changed");
    // a dual-variant part never runs more than two phases
    AST_PHASE_CAP: assert property (!i_quad_variant [*4] |->
        o_phases_first <= 3'h2) else $error("phase cap broken");
    AST_ACTIVE_MAP: assert property (o_phase_active_first ==
        (4'h1 << o_phases_first) - 4'h1) else $error("active map wrong");
    AST_THREE_SHIFT: assert property (o_phases_first == 3'h3 |->
        o_phase_shift_deg_1 == 8'h5a && o_phase_shift_deg_2 == 8'hb4) else $error("shift wrong");
    AST_CFG_OUT: assert property (wr_hit && i_addr == 8'hd3 |-> ##2
        o_shed_enable_second == $past(i_wr_data[4], 2) && o_shed_enable_first == $past(i_wr_data[3], 2)
        && o_phases_second == {1'h0, $past(i_wr_data[2], 2)} + 2'h1) else $error("config outputs wrong");
    // ----------------------------------------
    // covers
    // ----------------------------------------
    COV_CFG: cover property (wr_hit && i_addr == 8'hd3);
    COV_THREE: cover property (o_phases_first == 3'h3);
    COV_FUSE: cover property ($rose(i_fuse_load));
    COV_READ: cover property (i_rd_en && i_page_hit && i_addr == 8'hd7);
endmodule
bind buck_phase_voltage_regs buck_phase_voltage_regs_chk u_chk (.*);
`default_nettype wire

/* buck_phase_voltage_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "buck_regs_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module buck_phase_voltage_regs_tb_top;
    // ----------------------------------------
    // design signals
    // ----------------------------------------
    logic        i_core_clk;
    logic        i_nrst = 1'h0;
    logic [7:0]  i_addr = 8'h00;
    logic        i_page_hit = 1'h1;
    logic        i_wr_en = 1'h0;
    logic [7:0]  i_wr_data = 8'h00;
    logic        i_rd_en = 1'h0;
    logic        i_quad_variant = 1'h0;
    logic        i_test_mode = 1'h0;
    logic        i_fuse_load = 1'h0;
    logic [6:0]  i_fuse_ceiling_first = 7'h00;
    logic [6:0]  i_fuse_ceiling_second = 7'h00;
    logic [7:0]  o_rd_data, o_phase_shift_deg_1, o_phase_shift_deg_2, o_phase_shift_deg_3;
    logic [2:0]  o_phases_first;
    logic [3:0]  o_phase_active_first;
    logic [1:0]  o_phases_second;
    logic        o_shed_enable_first, o_shed_enable_second;
    logic [6:0]  o_setpoint_first_a, o_setpoint_first_b, o_setpoint_second_a, o_setpoint_second_b;
    logic [6:0]  o_ceiling_code_first, o_ceiling_code_second;
    logic [10:0] o_setpoint_first_a_mv, o_ceiling_first_mv;
    // bench state
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [7:0]  d, a;
    logic        q;
    buck_phase_voltage_regs DUT (.*);
    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        i_core_clk = 1'h0;
        forever #20 i_core_clk = ~i_core_clk;
    end
    // generous ceiling, the run needs under a thousand cycles
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // expected phase count, capped on the dual part
    function automatic logic [2:0] nph(input logic [7:0] c, input logic v);
        nph = (!v && c[1]) ? 3'h2 : {1'h0, c[1:0]} + 3'h1;
    endfunction
    // expected level in millivolts
    function automatic logic [10:0] mv(input logic [6:0] c);
        mv = 11'h12c + 11'h00a * {4'h0, c};
    endfunction
    // observed setpoint output that belongs to an offset
    function automatic logic [6:0] sp_out(input logic [7:0] ad);
        case (ad)
            `OFS_SETPOINT_FIRST_A: sp_out = o_setpoint_first_a;
            `OFS_SETPOINT_FIRST_B: sp_out = o_setpoint_first_b;
            `OFS_SETPOINT_SECOND_A: sp_out = o_setpoint_second_a;
            default: sp_out = o_setpoint_second_b;
        endcase
    endfunction
    // one-cycle write strobe
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(posedge i_core_clk);
        i_addr <= ad;
        i_wr_data <= v;
        i_wr_en <= 1'h1;
        @(posedge i_core_clk);
        i_wr_en <= 1'h0;
    endtask
    // one-cycle read strobe, data checked once it has landed
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge i_core_clk);
        i_addr <= ad;
        i_rd_en <= 1'h1;
        @(posedge i_core_clk);
        i_rd_en <= 1'h0;
        #1;
        `CHK(o_rd_data, e)
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h45e4af05));
        repeat (12) @(posedge i_core_clk);
        i_nrst <= 1'h1;
        // reset values, unmapped hole reads zero
        rd(`OFS_PHASE_CONFIG, `RST_PHASE_CONFIG);
        rd(`OFS_CEILING_FIRST, 8'h7f);
        rd(`OFS_CEILING_SECOND, 8'h7f);
        for (int k = 0; k < 4; k++) rd(8'hd7 + k[7:0], 8'h46);
        rd(8'hd4, 8'h00);
        `CHK(o_setpoint_first_a_mv, 11'h3e8)
        // code ends and random codes on the converted level
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            wr(`OFS_SETPOINT_FIRST_A, d);
            #1;
            `CHK(o_setpoint_first_a_mv, mv(d[6:0]))
            `CHK(o_ceiling_first_mv, mv(`RST_CEILING))
        end
        // random setpoint traffic, top bit must drop
        repeat (16) begin
            d = 8'($urandom);
            a = 8'hd7 + 8'($urandom % 4);
            wr(a, d);
            rd(a, {1'h0, d[6:0]});
            `CHK(sp_out(a), d[6:0])
        end
        // off-page write is ignored
        wr(`OFS_SETPOINT_FIRST_B, 8'h33);
        @(posedge i_core_clk) i_page_hit <= 1'h0;
        wr(`OFS_SETPOINT_FIRST_B, 8'h11);
        @(posedge i_core_clk) i_page_hit <= 1'h1;
        rd(`OFS_SETPOINT_FIRST_B, 8'h33);
        // every config code on both variants, junk in reserved bits
        for (int i = 0; i < 64; i++) begin
            d = {3'($urandom), i[4:0]};
            q = i[5];
            @(posedge i_core_clk) i_quad_variant <= q;
            wr(`OFS_PHASE_CONFIG, d);
            repeat (4) @(posedge i_core_clk);
            #1;
            `CHK(o_phases_first, nph(d, q))
            `CHK(o_phase_active_first, (4'h1 << nph(d, q)) - 4'h1)
            `CHK(o_shed_enable_first, d[3])
            `CHK(o_shed_enable_second, d[4])
            `CHK(o_phases_second, {1'h0, d[2]} + 2'h1)
            if (nph(d, q) == 3'h3) begin
                `CHK({o_phase_shift_deg_1, o_phase_shift_deg_2}, 16'h5ab4)
            end
            if (nph(d, q) == 3'h4) begin
                `CHK({o_phase_shift_deg_1, o_phase_shift_deg_2, o_phase_shift_deg_3}, 24'h5ab40e)
            end
            rd(`OFS_PHASE_CONFIG, d & 8'h1f);
        end
        // ceiling locked outside test mode, writable inside it
        wr(`OFS_CEILING_FIRST, 8'h15);
        rd(`OFS_CEILING_FIRST, 8'h7f);
        @(posedge i_core_clk) i_test_mode <= 1'h1;
        repeat (3) @(posedge i_core_clk);
        wr(`OFS_CEILING_FIRST, 8'h95);
        rd(`OFS_CEILING_FIRST, 8'h15);
        wr(`OFS_CEILING_SECOND, 8'h2a);
        rd(`OFS_CEILING_SECOND, 8'h2a);
        @(posedge i_core_clk) i_test_mode <= 1'h0;
        // fuse load with random fuse contents
        i_fuse_ceiling_first <= 7'($urandom);
        i_fuse_ceiling_second <= 7'($urandom);
        repeat (3) @(posedge i_core_clk);
        i_fuse_load <= 1'h1;
        repeat (2) @(posedge i_core_clk);
        i_fuse_load <= 1'h0;
        repeat (6) @(posedge i_core_clk);
        rd(`OFS_CEILING_FIRST, {1'h0, i_fuse_ceiling_first});
        rd(`OFS_CEILING_SECOND, {1'h0, i_fuse_ceiling_second});
        `CHK(o_ceiling_first_mv, mv(i_fuse_ceiling_first))
        `CHK(o_ceiling_code_second, i_fuse_ceiling_second)
        // mid-run reset brings every register back to its default
        @(posedge i_core_clk) i_nrst <= 1'h0;
        repeat (2) @(posedge i_core_clk);
        i_nrst <= 1'h1;
        rd(`OFS_PHASE_CONFIG, `RST_PHASE_CONFIG);
        rd(`OFS_CEILING_FIRST, {1'h0, `RST_CEILING});
        rd(`OFS_SETPOINT_SECOND_B, {1'h0, `RST_SETPOINT});
        `CHK(o_shed_enable_second, 1'h1)
        `CHK(o_phases_second, 2'h2)
        `CHK(o_phases_first, 3'h4)
        print_verdict();
    end
endmodule
`default_nettype wire

/* buck_regs_map.vh */
`ifndef BUCK_REGS_MAP_VH
`define BUCK_REGS_MAP_VH

// ----------------------------------------
// register offsets (byte offsets within the page)
// ----------------------------------------
`define OFS_PHASE_CONFIG     8'hd3
`define OFS_CEILING_FIRST    8'hd5
`define OFS_CEILING_SECOND   8'hd6
`define OFS_SETPOINT_FIRST_A 8'hd7
`define OFS_SETPOINT_FIRST_B 8'hd8
`define OFS_SETPOINT_SECOND_A 8'hd9
`define OFS_SETPOINT_SECOND_B 8'hda

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_SHED_SECOND      4
`define BIT_SHED_FIRST       3
`define BIT_PHASE_SECOND     2
`define PHASE_FIRST_HI       1
`define PHASE_FIRST_LO       0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PHASE_CONFIG     8'h1f
`define RST_PHASE_STORED     5'h1f
`define RST_CEILING          7'h7f
`define RST_SETPOINT         7'h46

// ----------------------------------------
// voltage code scale, millivolts
// ----------------------------------------
`define VCODE_BASE_MV        11'h12c
`define VCODE_STEP_MV        11'h00a

`endif

/* vcode_reg.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// one 7-bit voltage code register
// ----------------------------------------
module vcode_reg #(
    parameter [6:0] RESET_CODE = 7'h46
) (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_nrst,
    // write side
    input  wire       i_load,
    input  wire [6:0] i_code,
    // stored code
    output reg  [6:0] o_code
);

    // bit 7 is never stored, so it always reads zero
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_code <= RESET_CODE;
        end else if (i_load) begin
            o_code <= i_code;
        end
    end

endmodule

`default_nettype wire

/* vcode_to_mv.v */
`timescale 1ns/1ps
`default_nettype none

`include "buck_regs_map.vh"

// ----------------------------------------
// linear code to millivolt conversion
// ----------------------------------------
module vcode_to_mv (
    // code in
    input  wire [6:0]  i_code,
    // level in millivolts, combinational
    output wire [10:0] o_mv
);

    // 300 mV + 10 mV per step, 1270 mV span fits 11 bits
    wire [10:0] step_total;   // code times step

    assign step_total = {4'h0, i_code} * `VCODE_STEP_MV;
    assign o_mv       = `VCODE_BASE_MV + step_total;

endmodule

`default_nettype wire
